// ===== design/cst_top.sv
// Capture unit: five capture modules, three 16-bit time-base timers, APB slave.
// Assumes pins are synchronous to CLK_I and the master follows APB sequencing.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ns
module cst_top #(
   parameter bit LARGE_PKG = 1'b1
) (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire cst_pkg::cst_apb_req_s APB_REQ_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   input wire logic SLEEP_I,
   input wire logic [cst_pkg::NMOD-1:0] CAP_PIN_I,
   input wire logic [cst_pkg::NTMR-1:0] SOSC_TICK_I,
   input wire logic [cst_pkg::NTMR-1:0] TIMER_EXT_CLOCK_PIN_I,
   output logic [cst_pkg::NMOD-1:0] CAPTURE_EVENT_FLAG_O,
   output logic [7:0] PORTD_DIR_O,
   output logic [7:0] PORTE_DIR_O
);
   import cst_pkg::*;

   if (NMOD != 5 || NTMR != 3) begin : g_bad_cfg
      $error("cst_top: module or timer count unsupported");
   end

   cst_ctrl_s ctrl_r [NMOD];
   logic [15:0] capv_r [NMOD];
   logic [3:0] presc_r [NMOD];
   logic [NMOD-1:0] pin_d_r;
   logic [NMOD-1:0] flag_r;
   logic [NMOD-1:0] ien_r;
   logic [7:0] tsela_r;
   logic [7:0] tselb_r;
   logic [7:0] tcfg_r [NTMR];
   logic [15:0] tcnt_r [NTMR];
   logic [NTMR-1:0] ext_d_r;
   logic [1:0] div_r;
   logic [7:0] dird_r;
   logic [7:0] dire_r;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;

   logic acc;
   logic wr_fire;
   logic [7:0] wbyte;
   logic [31:0] rd_data;
   logic rd_hit;
   logic [NTMR-1:0] tmr_run;
   logic [NMOD-1:0] cap_evt;
   logic [NMOD-1:0] flag_wr_en;
   logic [NMOD-1:0] flag_wr_val;
   logic [15:0] cap_src [NMOD];

   function automatic logic [7:0] slot(input logic [7:0] base, input logic [7:0] step,
                                       input int idx);
      slot = base + 8'(idx) * step;
   endfunction : slot

   function automatic logic [7:0] ctrl_mask(input int m);
      ctrl_mask = (m < NENH) ? CTRL_MASK_ENH : CTRL_MASK_STD;
   endfunction : ctrl_mask

   function automatic logic [1:0] tsel_of(input logic [7:0] a, input logic [7:0] b,
                                          input int m);
      tsel_of = (m < NENH) ? a[TSEL_LSB[m] +: 2] : b[TSEL_LSB[m] +: 2];
   endfunction : tsel_of

   function automatic logic is_cap_mode(input logic [3:0] mode);
      is_cap_mode = (mode == MODE_FALL) || (mode == MODE_RISE) ||
                    (mode == MODE_RISE4) || (mode == MODE_RISE16);
   endfunction : is_cap_mode

   assign acc = APB_REQ_I.psel && APB_REQ_I.penable;
   assign wr_fire = acc && APB_REQ_I.pwrite && PREADY_O;
   assign wbyte = APB_REQ_I.pwdata[7:0];

   // Read decode; write decode below uses the same slots
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b0;
      for (int m = 0; m < NMOD; m++) begin
         if (APB_REQ_I.paddr == slot(A_CTRL0, STEP_W, m)) begin
            rd_hit = 1'b1;
            rd_data[7:0] = ctrl_r[m];
         end
         if (APB_REQ_I.paddr == slot(A_VALH0, STEP_VAL, m)) begin
            rd_hit = 1'b1;
            rd_data[7:0] = capv_r[m][15:8];
         end
         if (APB_REQ_I.paddr == slot(A_VALL0, STEP_VAL, m)) begin
            rd_hit = 1'b1;
            rd_data[7:0] = capv_r[m][7:0];
         end
      end
      for (int t = 0; t < NTMR; t++) begin
         if (APB_REQ_I.paddr == slot(A_TCFG0, STEP_W, t)) begin
            rd_hit = 1'b1;
            rd_data[7:0] = tcfg_r[t];
         end
         if (APB_REQ_I.paddr == slot(A_TCNT0, STEP_W, t)) begin
            rd_hit = 1'b1;
            rd_data[15:0] = tcnt_r[t];
         end
      end
      if (APB_REQ_I.paddr == A_TSELA) begin
         rd_hit = 1'b1;
         rd_data[7:0] = tsela_r;
      end
      if (APB_REQ_I.paddr == A_TSELB) begin
         rd_hit = 1'b1;
         rd_data[7:0] = tselb_r;
      end
      if (APB_REQ_I.paddr == A_IEN1) begin
         rd_hit = 1'b1;
         rd_data[FLG1_BIT] = ien_r[0];
      end
      if (APB_REQ_I.paddr == A_IEN2) begin
         rd_hit = 1'b1;
         rd_data[FLG2_BIT] = ien_r[1];
      end
      if (APB_REQ_I.paddr == A_IEN4) begin
         rd_hit = 1'b1;
         rd_data[2:0] = ien_r[NMOD-1:FLG4_MOD0];
      end
      if (APB_REQ_I.paddr == A_FLG1) begin
         rd_hit = 1'b1;
         rd_data[FLG1_BIT] = flag_r[0];
      end
      if (APB_REQ_I.paddr == A_FLG2) begin
         rd_hit = 1'b1;
         rd_data[FLG2_BIT] = flag_r[1];
      end
      if (APB_REQ_I.paddr == A_FLG4) begin
         rd_hit = 1'b1;
         rd_data[2:0] = flag_r[NMOD-1:FLG4_MOD0];
      end
      if (APB_REQ_I.paddr == A_DIRD) begin
         rd_hit = 1'b1;
         rd_data[7:0] = dird_r;
      end
      if (APB_REQ_I.paddr == A_DIRE) begin
         rd_hit = 1'b1;
         rd_data[7:0] = dire_r;
      end
   end

   // Two wait states; writes wait for PREADY_O so they land with the master's sample
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else if (acc && !pready_r && !PREADY_O) begin
         pready_r <= 1'b1;
         pslverr_r <= !rd_hit;
         prdata_r <= APB_REQ_I.pwrite ? 32'h0000_0000 : rd_data;
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         for (int m = 0; m < NMOD; m++) begin
            ctrl_r[m] <= RST_BYTE;
         end
      end else if (wr_fire) begin
         for (int m = 0; m < NMOD; m++) begin
            if (APB_REQ_I.paddr == slot(A_CTRL0, STEP_W, m)) begin
               ctrl_r[m] <= wbyte & ctrl_mask(m);
            end
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         tsela_r <= RST_BYTE;
         tselb_r <= RST_BYTE;
         ien_r <= '0;
      end else if (wr_fire) begin
         if (APB_REQ_I.paddr == A_TSELA) begin
            tsela_r <= wbyte & TSELA_MASK;
         end
         if (APB_REQ_I.paddr == A_TSELB) begin
            tselb_r <= wbyte & TSELB_MASK;
         end
         if (APB_REQ_I.paddr == A_IEN1) begin
            ien_r[0] <= wbyte[FLG1_BIT];
         end
         if (APB_REQ_I.paddr == A_IEN2) begin
            ien_r[1] <= wbyte[FLG2_BIT];
         end
         if (APB_REQ_I.paddr == A_IEN4) begin
            ien_r[NMOD-1:FLG4_MOD0] <= wbyte[2:0];
         end
      end
   end

   // Direction registers only exist on the larger package
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         dird_r <= LARGE_PKG ? DIR_RST : RST_BYTE;
         dire_r <= LARGE_PKG ? (DIR_RST & DIRE_MASK) : RST_BYTE;
      end else if (wr_fire && LARGE_PKG) begin
         if (APB_REQ_I.paddr == A_DIRD) begin
            dird_r <= wbyte;
         end
         if (APB_REQ_I.paddr == A_DIRE) begin
            dire_r <= wbyte & DIRE_MASK;
         end
      end
   end

   // Instruction-clock enable: one pulse every fourth system cycle
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         div_r <= 2'h0;
      end else begin
         div_r <= div_r + 2'h1;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         ext_d_r <= '0;
      end else begin
         ext_d_r <= TIMER_EXT_CLOCK_PIN_I;
      end
   end

   always_comb begin
      for (int t = 0; t < NTMR; t++) begin
         logic tick;
         logic [1:0] src;
         tick = 1'b0;
         src = tcfg_r[t][1:0];
         unique case (src)
            SRC_FOSC: tick = 1'b1;
            SRC_INSTR: tick = (div_r == INSTR_LAST);
            SRC_SOSC: tick = SOSC_TICK_I[t];
            SRC_EXTPIN: tick = TIMER_EXT_CLOCK_PIN_I[t] && !ext_d_r[t];
         endcase
         // Internal clocks stop in sleep; the count is simply held
         tmr_run[t] = tcfg_r[t][TCFG_ON_BIT] && tick &&
                      !(SLEEP_I && (src == SRC_FOSC || src == SRC_INSTR));
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         for (int t = 0; t < NTMR; t++) begin
            tcfg_r[t] <= RST_BYTE;
            tcnt_r[t] <= RST_WORD;
         end
      end else begin
         for (int t = 0; t < NTMR; t++) begin
            if (wr_fire && APB_REQ_I.paddr == slot(A_TCFG0, STEP_W, t)) begin
               tcfg_r[t] <= wbyte & TCFG_MASK;
            end
            if (wr_fire && APB_REQ_I.paddr == slot(A_TCNT0, STEP_W, t)) begin
               tcnt_r[t] <= APB_REQ_I.pwdata[15:0];
            end else if (tmr_run[t]) begin
               tcnt_r[t] <= tcnt_r[t] + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         pin_d_r <= '0;
      end else begin
         pin_d_r <= CAP_PIN_I;
      end
   end

   // Event detection per module
   always_comb begin
      for (int m = 0; m < NMOD; m++) begin
         logic [1:0] sel;
         logic [3:0] mode;
         logic attached;
         logic rise;
         logic fall;
         sel = tsel_of(tsela_r, tselb_r, m);
         mode = ctrl_r[m].module_mode_select;
         rise = CAP_PIN_I[m] && !pin_d_r[m];
         fall = !CAP_PIN_I[m] && pin_d_r[m];
         attached = 1'b0;
         cap_src[m] = RST_WORD;
         if (sel != TSEL_NONE) begin
            attached = tcfg_r[sel][TCFG_ON_BIT];
            cap_src[m] = tcnt_r[sel];
         end
         cap_evt[m] = 1'b0;
         if (attached) begin
            unique case (mode)
               MODE_FALL: cap_evt[m] = fall;
               MODE_RISE: cap_evt[m] = rise;
               MODE_RISE4: cap_evt[m] = rise && presc_r[m][1:0] == PRE4_LAST;
               MODE_RISE16: cap_evt[m] = rise && presc_r[m] == PRE16_LAST;
               default: cap_evt[m] = 1'b0;
            endcase
         end
      end
   end

   // Prescaler survives a ratio change, so switching ratios can fire early
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         for (int m = 0; m < NMOD; m++) begin
            presc_r[m] <= 4'h0;
         end
      end else begin
         for (int m = 0; m < NMOD; m++) begin
            if (!is_cap_mode(ctrl_r[m].module_mode_select)) begin
               presc_r[m] <= 4'h0;
            end else if (CAP_PIN_I[m] && !pin_d_r[m] &&
                         (ctrl_r[m].module_mode_select == MODE_RISE4 ||
                          ctrl_r[m].module_mode_select == MODE_RISE16)) begin
               presc_r[m] <= presc_r[m] + 4'h1;
            end
         end
      end
   end

   // Captured value: a capture beats a software write in the same cycle
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         for (int m = 0; m < NMOD; m++) begin
            capv_r[m] <= RST_WORD;
         end
      end else begin
         for (int m = 0; m < NMOD; m++) begin
            if (cap_evt[m]) begin
               capv_r[m] <= cap_src[m];
            end else if (wr_fire && APB_REQ_I.paddr == slot(A_VALH0, STEP_VAL, m)) begin
               capv_r[m][15:8] <= wbyte;
            end else if (wr_fire && APB_REQ_I.paddr == slot(A_VALL0, STEP_VAL, m)) begin
               capv_r[m][7:0] <= wbyte;
            end
         end
      end
   end

   always_comb begin
      flag_wr_en = '0;
      flag_wr_val = '0;
      if (wr_fire) begin
         if (APB_REQ_I.paddr == A_FLG1) begin
            flag_wr_en[0] = 1'b1;
            flag_wr_val[0] = wbyte[FLG1_BIT];
         end
         if (APB_REQ_I.paddr == A_FLG2) begin
            flag_wr_en[1] = 1'b1;
            flag_wr_val[1] = wbyte[FLG2_BIT];
         end
         if (APB_REQ_I.paddr == A_FLG4) begin
            flag_wr_en[NMOD-1:FLG4_MOD0] = 3'h7;
            flag_wr_val[NMOD-1:FLG4_MOD0] = wbyte[2:0];
         end
      end
   end

   // Sticky flags; a capture in the clearing cycle keeps the flag set
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         flag_r <= '0;
      end else begin
         flag_r <= ((flag_r & ~flag_wr_en) | (flag_wr_val & flag_wr_en)) | cap_evt;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I) begin
         PRDATA_O <= 32'h0000_0000;
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         CAPTURE_EVENT_FLAG_O <= '0;
         PORTD_DIR_O <= RST_BYTE;
         PORTE_DIR_O <= RST_BYTE;
      end else begin
         PRDATA_O <= prdata_r;
         PREADY_O <= pready_r;
         PSLVERR_O <= pslverr_r;
         CAPTURE_EVENT_FLAG_O <= flag_r;
         PORTD_DIR_O <= dird_r;
         PORTE_DIR_O <= dire_r;
      end
   end
endmodule : cst_top

// ===== design/cst_pkg.sv
// Constants, register map and carrier types of the capture unit.
// Assumes a 32-bit APB master and a single 250 MHz clock.
package cst_pkg;
   localparam int NMOD = 5;
   localparam int NTMR = 3;
   localparam int NENH = 3;
   localparam int CLK_MHZ = 250;

   // Byte addresses
   localparam logic [7:0] A_CTRL0 = 8'h00;
   localparam logic [7:0] A_VALH0 = 8'h20;
   localparam logic [7:0] A_VALL0 = 8'h24;
   localparam logic [7:0] A_TSELA = 8'h50;
   localparam logic [7:0] A_TSELB = 8'h54;
   localparam logic [7:0] A_IEN1 = 8'h58;
   localparam logic [7:0] A_IEN2 = 8'h5c;
   localparam logic [7:0] A_IEN4 = 8'h60;
   localparam logic [7:0] A_FLG1 = 8'h64;
   localparam logic [7:0] A_FLG2 = 8'h68;
   localparam logic [7:0] A_FLG4 = 8'h6c;
   localparam logic [7:0] A_TCFG0 = 8'h70;
   localparam logic [7:0] A_TCNT0 = 8'h80;
   localparam logic [7:0] A_DIRD = 8'h90;
   localparam logic [7:0] A_DIRE = 8'h94;
   localparam logic [7:0] STEP_W = 8'h04;
   localparam logic [7:0] STEP_VAL = 8'h08;

   // Implemented bits
   localparam logic [7:0] CTRL_MASK_ENH = 8'hff;
   localparam logic [7:0] CTRL_MASK_STD = 8'h3f;
   localparam logic [7:0] TSELA_MASK = 8'hdb;
   localparam logic [7:0] TSELB_MASK = 8'h0f;
   localparam logic [7:0] TCFG_MASK = 8'h07;
   localparam logic [7:0] DIRE_MASK = 8'h07;
   localparam int TSEL_LSB [NMOD] = '{0, 3, 6, 0, 2};
   localparam int FLG1_BIT = 2;
   localparam int FLG2_BIT = 0;
   localparam int FLG4_MOD0 = 2;
   localparam int TCFG_ON_BIT = 2;

   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] DIR_RST = 8'hff;

   // Capture modes
   localparam logic [3:0] MODE_FALL = 4'h4;
   localparam logic [3:0] MODE_RISE = 4'h5;
   localparam logic [3:0] MODE_RISE4 = 4'h6;
   localparam logic [3:0] MODE_RISE16 = 4'h7;
   localparam logic [1:0] PRE4_LAST = 2'h3;
   localparam logic [3:0] PRE16_LAST = 4'hf;

   // Time-base clock sources and selection
   localparam logic [1:0] SRC_FOSC = 2'h0;
   localparam logic [1:0] SRC_INSTR = 2'h1;
   localparam logic [1:0] SRC_SOSC = 2'h2;
   localparam logic [1:0] SRC_EXTPIN = 2'h3;
   localparam logic [1:0] INSTR_LAST = 2'h3;
   localparam logic [1:0] TSEL_NONE = 2'h3;

   typedef struct packed {
      logic [1:0] output_config;
      logic [1:0] duty_low_bits;
      logic [3:0] module_mode_select;
   } cst_ctrl_s;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } cst_apb_req_s;
endpackage : cst_pkg

// ===== tb/cst_props.sv
// Port-level checker for the capture unit, bound onto cst_top.
// Assumes the master holds a request until PREADY_O is sampled high.
`timescale 1ns/1ns
module cst_props import cst_pkg::*; (
   input wire logic CLK_I,
   input wire logic SYS_RST_I,
   input wire cst_apb_req_s APB_REQ_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   input wire logic [NMOD-1:0] CAP_PIN_I,
   input wire logic [NMOD-1:0] CAPTURE_EVENT_FLAG_O,
   input wire logic [7:0] PORTE_DIR_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   logic acc;
   logic flg_wr;
   assign acc = APB_REQ_I.psel && APB_REQ_I.penable;
   assign flg_wr = acc && APB_REQ_I.pwrite && PREADY_O &&
                   (APB_REQ_I.paddr inside {A_FLG1, A_FLG2, A_FLG4});
   sequence s_start;
      $rose(acc);
   endsequence
   sequence s_wait;
      !PREADY_O ##1 !PREADY_O ##1 PREADY_O;
   endsequence
   a_ready_late: assert property (s_start |-> s_wait)
      else $error("ready not two cycles after access");
   a_ready_pulse: assert property (PREADY_O |=> !PREADY_O)
      else $error("ready longer than one cycle");
   a_ready_held: assert property (PREADY_O |-> acc)
      else $error("ready outside access");
   a_err_ready: assert property (PSLVERR_O |-> PREADY_O)
      else $error("error without ready");
   a_err_unmap: assert property (PREADY_O && APB_REQ_I.paddr == 8'hfc |-> PSLVERR_O)
      else $error("unmapped address accepted");
   a_err_rdzero: assert property (PSLVERR_O && !APB_REQ_I.pwrite |-> PRDATA_O == 32'h0)
      else $error("refused read data not zero");
   a_data_hold: assert property ($changed(PRDATA_O) |-> PREADY_O || $past(SYS_RST_I))
      else $error("read data changed between transfers");
   a_dire_top: assert property (PORTE_DIR_O[7:3] == 5'h00)
      else $error("absent direction bits set");
   for (genvar m = 0; m < NMOD; m++) begin : g_m
      a_flag_cause: assert property ($rose(CAPTURE_EVENT_FLAG_O[m]) |->
         $past(CAP_PIN_I[m], 2) != $past(CAP_PIN_I[m], 3))
         else $error("flag set without pin change");
      a_flag_sticky: assert property ($fell(CAPTURE_EVENT_FLAG_O[m]) |-> $past(flg_wr, 2))
         else $error("flag cleared without software write");
   end
endmodule : cst_props

bind cst_top cst_props u_props (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .APB_REQ_I(APB_REQ_I),
   .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CAP_PIN_I(CAP_PIN_I),
   .CAPTURE_EVENT_FLAG_O(CAPTURE_EVENT_FLAG_O), .PORTE_DIR_O(PORTE_DIR_O));

// ===== tb/cst_far.sv
// Far side of the capture unit: event pins, oscillator ticks, timer clock pins.
// Assumes the caller runs its tasks one at a time from the bench.
`timescale 1ns/1ns
module cst_far import cst_pkg::*; (
   input wire logic clk_i,
   output logic [NMOD-1:0] cap_pin_o,
   output logic [NTMR-1:0] sosc_tick_o,
   output logic [NTMR-1:0] ext_clk_o
);
   initial begin
      cap_pin_o = '0;
      sosc_tick_o = '0;
      ext_clk_o = '0;
   end
   // Levels stand at least three cycles so no change is lost to the edge detector
   task automatic pin_set(input int m, input logic v);
      @(posedge clk_i);
      cap_pin_o[m] <= v;
      repeat (2) @(posedge clk_i);
   endtask : pin_set
   task automatic rise(input int m, input int n);
      repeat (n) begin
         pin_set(m, 1'b1);
         pin_set(m, 1'b0);
      end
   endtask : rise
   task automatic tick(input int t, input int n);
      repeat (n) begin
         @(posedge clk_i);
         sosc_tick_o[t] <= 1'b1;
         @(posedge clk_i);
         sosc_tick_o[t] <= 1'b0;
      end
   endtask : tick
   task automatic ext(input int t, input int n);
      repeat (n) begin
         @(posedge clk_i);
         ext_clk_o[t] <= 1'b1;
         repeat (2) @(posedge clk_i);
         ext_clk_o[t] <= 1'b0;
         repeat (2) @(posedge clk_i);
      end
   endtask : ext
endmodule : cst_far

// ===== tb/cst_bench.sv
// Self-checking bench for the capture unit over APB.
// Assumes the package register map and a 250 MHz clock.
`timescale 1ns/1ns
module cst_bench import cst_pkg::*;;
   logic CLK_I = 1'b0;
   logic SYS_RST_I = 1'b1;
   logic SLEEP_I = 1'b0;
   cst_apb_req_s req = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [NMOD-1:0] cap;
   logic [NMOD-1:0] flag;
   logic [NTMR-1:0] sosc;
   logic [NTMR-1:0] ext;
   logic [7:0] dird;
   logic [7:0] dire;
   logic [31:0] c1;
   logic [31:0] c2;
   logic e;
   int miscompares = 0;
   int checks = 0;
   always #2 CLK_I = ~CLK_I;
   cst_top u_cst_top (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .APB_REQ_I(req), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .SLEEP_I(SLEEP_I), .CAP_PIN_I(cap),
      .SOSC_TICK_I(sosc), .TIMER_EXT_CLOCK_PIN_I(ext), .CAPTURE_EVENT_FLAG_O(flag),
      .PORTD_DIR_O(dird), .PORTE_DIR_O(dire));
   cst_far u_cst_far (.clk_i(CLK_I), .cap_pin_o(cap), .sosc_tick_o(sosc), .ext_clk_o(ext));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge CLK_I);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge CLK_I);
      req.penable <= 1'b1;
      do begin
         @(posedge CLK_I);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         miscompares++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      req <= '0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic x;
      apb(1'b1, a, d, r, x);
      chk("write error", 32'h0, {31'h0, x});
   endtask : wr
   task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic x;
      apb(1'b0, a, 32'h0, r, x);
      chk(what, exp, r);
   endtask : rdc
   task automatic print_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   task automatic t_regs;
      rdc("ctrl1 reset", A_CTRL0, 32'h0);
      rdc("dird reset", A_DIRD, {24'h0, DIR_RST});
      rdc("dire reset", A_DIRE, {24'h0, DIR_RST & DIRE_MASK});
      chk("dird pin", 32'hff, {24'h0, dird});
      apb(1'b0, 8'hfc, 32'h0, c1, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      chk("unmapped data", 32'h0, c1);
      wr(A_DIRE, 32'hff);
      rdc("dire mask", A_DIRE, 32'h07);
      chk("dire pin", 32'h07, {24'h0, dire});
      wr(A_IEN4, 32'hff);
      rdc("ien4 mask", A_IEN4, 32'h07);
      wr(A_CTRL0 + 8'h0c, 32'hff);
      rdc("ctrl4 mask", A_CTRL0 + 8'h0c, 32'h3f);
      wr(A_CTRL0, 32'hff);
      rdc("ctrl1 full", A_CTRL0, 32'hff);
      wr(A_TSELA, 32'hff);
      rdc("tsela mask", A_TSELA, 32'hdb);
      wr(A_TSELB, 32'hff);
      rdc("tselb mask", A_TSELB, 32'h0f);
      wr(A_CTRL0, 32'h0);
      wr(A_CTRL0 + 8'h0c, 32'h0);
      wr(A_TSELA, 32'h0);
      $display("test regs done");
   endtask : t_regs
   task automatic t_capture;
      wr(A_TCNT0, 32'h1234);
      wr(A_TCFG0, 32'h06);
      wr(A_CTRL0, {28'h0, MODE_RISE});
      u_cst_far.tick(0, 3);
      u_cst_far.rise(0, 1);
      rdc("value high", A_VALH0, 32'h12);
      rdc("value low", A_VALL0, 32'h37);
      rdc("flag set", A_FLG1, 32'h04);
      chk("flag pin", 32'h01, {27'h0, flag});
      u_cst_far.tick(0, 1);
      u_cst_far.rise(0, 1);
      rdc("overwrite", A_VALL0, 32'h38);
      wr(A_FLG1, 32'h0);
      rdc("flag clear", A_FLG1, 32'h0);
      $display("test capture done");
   endtask : t_capture
   task automatic t_prescale;
      wr(A_CTRL0 + 8'h04, {28'h0, MODE_RISE4});
      u_cst_far.rise(1, 2);
      wr(A_CTRL0 + 8'h04, 32'h0);
      wr(A_CTRL0 + 8'h04, {28'h0, MODE_RISE4});
      u_cst_far.rise(1, 3);
      rdc("pre4 third", A_FLG2, 32'h0);
      u_cst_far.rise(1, 1);
      rdc("pre4 fourth", A_FLG2, 32'h1);
      wr(A_CTRL0 + 8'h08, {28'h0, MODE_RISE16});
      u_cst_far.rise(2, 15);
      rdc("pre16 last", A_FLG4, 32'h0);
      u_cst_far.rise(2, 1);
      rdc("pre16 hit", A_FLG4, 32'h1);
      wr(A_FLG4, 32'h0);
      $display("test prescale done");
   endtask : t_prescale
   task automatic t_sleep;
      wr(A_TCFG0 + 8'h04, 32'h04);
      wr(A_TCNT0 + 8'h08, 32'h00ff);
      wr(A_TCFG0 + 8'h08, 32'h07);
      wr(A_TSELB, 32'h0b);
      wr(A_CTRL0 + 8'h0c, {28'h0, MODE_RISE});
      wr(A_CTRL0 + 8'h10, {28'h0, MODE_FALL});
      u_cst_far.pin_set(4, 1'b1);
      @(posedge CLK_I);
      SLEEP_I <= 1'b1;
      apb(1'b0, A_TCNT0 + 8'h04, 32'h0, c1, e);
      rdc("held count", A_TCNT0 + 8'h04, c1);
      u_cst_far.ext(2, 2);
      u_cst_far.pin_set(4, 1'b0);
      u_cst_far.rise(3, 1);
      rdc("sleep flags", A_FLG4, 32'h04);
      rdc("sleep high", A_VALH0 + 8'h20, 32'h01);
      rdc("sleep low", A_VALL0 + 8'h20, 32'h01);
      @(posedge CLK_I);
      SLEEP_I <= 1'b0;
      apb(1'b0, A_TCNT0 + 8'h04, 32'h0, c2, e);
      chk("resume", 32'h1, {31'h0, c2 > c1 && c2 - c1 < 32'd20});
      $display("test sleep done");
   endtask : t_sleep
   // Reads 45 cycles apart, so a quarter-rate timer moves by 11 or 12
   task automatic t_instr;
      wr(A_TCFG0, 32'h05);
      apb(1'b0, A_TCNT0, 32'h0, c1, e);
      repeat (40) @(posedge CLK_I);
      apb(1'b0, A_TCNT0, 32'h0, c2, e);
      chk("instr rate", 32'h1, {31'h0, (c2 - c1 == 32'd11) || (c2 - c1 == 32'd12)});
      $display("test instr done");
   endtask : t_instr
   initial begin
      repeat (8) @(posedge CLK_I);
      SYS_RST_I <= 1'b0;
      t_regs();
      t_capture();
      t_prescale();
      t_sleep();
      t_instr();
      print_verdict();
   end
   // Whole run takes a few hundred cycles
   initial begin
      repeat (20000) @(posedge CLK_I);
      miscompares++;
      print_verdict();
   end
endmodule : cst_bench
